// ### ftm_defs.svh
// register offsets, field positions, reset values and timing counts of the fan tach monitor
// assumes a 50 MHz system clock; included by the package and the monitor module
//
// Function
// - period measured by gating a ~22.5 kHz oscillator into an 8-bit counter
// - writing one to bit 0 of configuration 1 starts the monitoring cycle
// - counter starts when a channel is selected; 0xFF means failed fan
// - counter clears at second rising tach edge, counts until the fourth
// - channels measured one at a time, 0 up to 7, repeated each cycle
// - 1.8 s spin-up wait after monitor set; tach results read 0x00 meanwhile
// - prescaler 1/2/4/8 per fan; fans 0-3 from 02h, fans 4-7 from 03h
// - every prescaler divides by two after reset
// - count equals oscillator frequency times 60 over RPM times divisor
// - only a low-speed limit per fan, no over-speed comparison
// - fan failure flagged and interrupt raised when count exceeds the limit
// - measurement aborts when counter reaches 255 before second or fourth edge
// - channel set as general-purpose pin is scanned and times out at 255
// - worst case per channel is 509 oscillator pulses times the divisor
// - fan and analog monitoring cycles start together, no further sync
// - configuration 2 bit clear means tach input, set means GPIO; resets 00h
`ifndef FTM_DEFS_SVH
`define FTM_DEFS_SVH

// ************************************************************
// register map
// ************************************************************
`define FTM_CFG1_OFS 8'h00
`define FTM_CFG2_OFS 8'h01
`define FTM_DIV_LO_OFS 8'h02
`define FTM_DIV_HI_OFS 8'h03
`define FTM_LIMIT_BASE 8'h10
`define FTM_RESULT_BASE 8'h18
`define FTM_FAIL_OFS 8'h20

// ************************************************************
// fields and reset values
// ************************************************************
`define FTM_MON_BIT 0
`define FTM_INTEN_BIT 1
`define FTM_CFG1_RST 8'h00
`define FTM_CFG2_RST 8'h00
`define FTM_DIV_RST 8'h55
`define FTM_LIMIT_RST 8'hFF
`define FTM_FULL 8'hFF

// ************************************************************
// timing
// ************************************************************
`define FTM_CLK_HZ 50000000
`define FTM_OSC_HZ 22500
`define FTM_OSC_CYC (`FTM_CLK_HZ / `FTM_OSC_HZ)
`define FTM_SPINUP_MS 1800
`define FTM_SPINUP_CYC (`FTM_CLK_HZ / 1000 * `FTM_SPINUP_MS)
`define FTM_WORST_PULSES 509

`endif

// ### ftm_fan_model.sv
// behavioural fan tach outputs for the eight monitor channels
// assumes it shares clk_i with the monitor and that the pins are pulled up
`timescale 1ns/1ps
`default_nettype none

module ftm_fan_model
    import ftm_pkg::*;
(
    // clock
    input wire logic clk_i,
    // per-channel tach period in clocks, zero means stopped
    input wire logic [7:0][15:0] period_i,
    // tach pins
    output logic [7:0] tach_o
);
    // ************************************************************
    // square wave generators
    // ************************************************************
    logic [7:0][15:0] phase;

    initial begin
        phase = '0;
        tach_o = 8'hFF;
    end

    // a stopped fan rests at the pull-up level, never at its last driven value
    always @(posedge clk_i) begin
        #1;
        for (int i = 0; i < 8; i++) begin
            if (period_i[i] == 16'h0000) begin
                phase[i] = 16'h0000;
                tach_o[i] = 1'b1;
            end else begin
                phase[i] = (phase[i] >= period_i[i] - 16'h0001) ? 16'h0000 : phase[i] + 16'h0001;
                tach_o[i] = (phase[i] < (period_i[i] >> 1));
            end
        end
    end
endmodule
`default_nettype wire

// ### ftm_monitor.sv
// sequential tach period monitor for eight fan inputs
// assumes asynchronous tach pins and a register port clocked by clk_i
`timescale 1ns/1ps
`default_nettype none
`include "ftm_defs.svh"

module ftm_monitor
    import ftm_pkg::*;
#(
    parameter int OSC_CYC = `FTM_OSC_CYC,
    parameter int SPINUP_CYC = `FTM_SPINUP_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire ftm_reg_req_s reg_req_i,
    output logic [7:0] reg_rdata_o,
    // fan pins
    input wire logic [7:0] tach_i,
    // status
    output logic [7:0] fan_fail_o,
    output logic int_n_o,
    output logic analog_start_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    // divisor field of a channel, two bits per fan in ascending order
    function automatic logic [1:0] div_code(input logic [7:0] lo, input logic [7:0] hi,
                                            input logic [2:0] ch);
        logic [7:0] grp;
        grp = ch[2] ? hi : lo;
        return grp[{ch[1:0], 1'b0} +: 2];
    endfunction

    // last prescaler state before a counted pulse: 1,2,4,8 -> 0,1,3,7
    function automatic logic [2:0] div_last(input logic [1:0] code);
        return 3'((4'h1 << code) - 4'h1);
    endfunction

    // true when an address falls in the eight-register block starting at base
    function automatic logic blk_hit(input logic [7:0] addr, input logic [7:0] base);
        return addr[7:3] == base[7:3];
    endfunction

    ftm_state_s r, n;
    logic osc_tick;
    logic cnt_tick;
    logic rise;
    logic is_gpio;
    logic store;
    logic [7:0] store_val;

    // ************************************************************
    // oscillator, prescaler and tach edge
    // ************************************************************
    // the oscillator is a tick from the system clock, so it has no drift of its own
    assign osc_tick = (r.osc == 16'(OSC_CYC - 1));
    assign cnt_tick = osc_tick && (r.psc == div_last(div_code(r.div_lo, r.div_hi, r.chan)));
    assign rise = r.sync2[r.chan] && !r.tprev[r.chan];
    assign is_gpio = r.cfg2[r.chan];

    assign reg_rdata_o = r.rdata;
    assign fan_fail_o = r.fail;
    assign int_n_o = !(r.cfg1[`FTM_INTEN_BIT] && (|r.fail));
    assign analog_start_o = r.astart;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        n = r;
        store = 1'b0;
        store_val = `FTM_FULL;
        n.astart = 1'b0;
        n.sync1 = tach_i;
        n.sync2 = r.sync1;
        n.tprev = r.sync2;
        n.osc = osc_tick ? 16'h0000 : r.osc + 16'h0001;
        if (osc_tick) begin
            n.psc = cnt_tick ? 3'h0 : r.psc + 3'h1;
        end

        case (r.state)
            FTM_ST_IDLE: begin
                if (r.cfg1[`FTM_MON_BIT]) begin
                    n.state = FTM_ST_SPIN;
                    n.spin = 32'h0;
                    n.result = '0;
                    n.astart = 1'b1;
                end
            end
            FTM_ST_SPIN: begin
                n.spin = r.spin + 32'h1;
                if (r.spin == 32'(SPINUP_CYC - 1)) begin
                    n.state = FTM_ST_INIT;
                    n.chan = 3'h0;
                    n.cnt = 8'h00;
                    n.psc = 3'h0;
                    n.edges = 2'h0;
                end
            end
            FTM_ST_INIT, FTM_ST_MEAS: begin
                if (cnt_tick) begin
                    n.cnt = r.cnt + 8'h01;
                end
                if (rise && !is_gpio) begin
                    if (r.state == FTM_ST_INIT && r.edges == 2'h1) begin
                        n.state = FTM_ST_MEAS;
                        n.cnt = 8'h00;
                        n.edges = 2'h2;
                    end else if (r.state == FTM_ST_MEAS && r.edges == 2'h3) begin
                        store = 1'b1;
                        store_val = r.cnt;
                    end else begin
                        n.edges = r.edges + 2'h1;
                    end
                end else if (cnt_tick && r.cnt >= `FTM_FULL - 8'h01) begin
                    store = 1'b1;
                    store_val = `FTM_FULL;
                end
                if (store) begin
                    n.result[r.chan] = store_val;
                    n.fail[r.chan] = store_val > r.limit[r.chan];
                    n.chan = r.chan + 3'h1;
                    n.state = FTM_ST_INIT;
                    n.cnt = 8'h00;
                    n.psc = 3'h0;
                    n.edges = 2'h0;
                end
            end
            default: begin
                n.state = FTM_ST_IDLE;
            end
        endcase

        // clearing the monitor bit stops the scan at once; results stay readable
        if (!r.cfg1[`FTM_MON_BIT] && r.state != FTM_ST_IDLE) begin
            n.state = FTM_ST_IDLE;
        end

        // register writes
        if (reg_req_i.wr) begin
            if (reg_req_i.addr == `FTM_CFG1_OFS) begin
                n.cfg1 = reg_req_i.wdata;
            end else if (reg_req_i.addr == `FTM_CFG2_OFS) begin
                n.cfg2 = reg_req_i.wdata;
            end else if (reg_req_i.addr == `FTM_DIV_LO_OFS) begin
                n.div_lo = reg_req_i.wdata;
            end else if (reg_req_i.addr == `FTM_DIV_HI_OFS) begin
                n.div_hi = reg_req_i.wdata;
            end else if (blk_hit(reg_req_i.addr, `FTM_LIMIT_BASE)) begin
                n.limit[reg_req_i.addr[2:0]] = reg_req_i.wdata;
            end
        end

        // register reads, answered one cycle after the strobe
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == `FTM_CFG1_OFS) begin
                n.rdata = r.cfg1;
            end else if (reg_req_i.addr == `FTM_CFG2_OFS) begin
                n.rdata = r.cfg2;
            end else if (reg_req_i.addr == `FTM_DIV_LO_OFS) begin
                n.rdata = r.div_lo;
            end else if (reg_req_i.addr == `FTM_DIV_HI_OFS) begin
                n.rdata = r.div_hi;
            end else if (blk_hit(reg_req_i.addr, `FTM_LIMIT_BASE)) begin
                n.rdata = r.limit[reg_req_i.addr[2:0]];
            end else if (blk_hit(reg_req_i.addr, `FTM_RESULT_BASE)) begin
                n.rdata = r.result[reg_req_i.addr[2:0]];
            end else if (reg_req_i.addr == `FTM_FAIL_OFS) begin
                n.rdata = r.fail;
            end else begin
                n.rdata = 8'h00;
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
            r.state <= FTM_ST_IDLE;
            r.cfg1 <= `FTM_CFG1_RST;
            r.cfg2 <= `FTM_CFG2_RST;
            r.div_lo <= `FTM_DIV_RST;
            r.div_hi <= `FTM_DIV_RST;
            r.limit <= {8{`FTM_LIMIT_RST}};
        end else begin
            r <= n;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // prescaled pulses spent on the current channel, for the worst-case bound
    logic [9:0] chan_ticks;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            chan_ticks <= 10'h000;
        end else if (store || r.state == FTM_ST_IDLE || r.state == FTM_ST_SPIN) begin
            chan_ticks <= 10'h000;
        end else if (cnt_tick) begin
            chan_ticks <= chan_ticks + 10'h001;
        end
    end

    sequence seq_second_edge;
        r.state == FTM_ST_INIT && rise && !is_gpio && r.edges == 2'h1 && r.cfg1[`FTM_MON_BIT]
            && !reg_req_i.wr;
    endsequence

    sequence seq_meas_cleared;
        r.state == FTM_ST_MEAS && r.cnt == 8'h00 && r.edges == 2'h2;
    endsequence

    AST_CLEAR_AT_SECOND: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_second_edge |=> seq_meas_cleared)
        else $error("count not cleared at second tach edge");

    AST_START_SPIN: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_IDLE && r.cfg1[`FTM_MON_BIT]
            |=> r.state == FTM_ST_SPIN && analog_start_o ##1 !analog_start_o)
        else $error("monitor bit did not start spin-up");

    AST_SPIN_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_SPIN |-> r.result == '0)
        else $error("tach result nonzero during spin-up");

    AST_ORDER: assert property (@(posedge clk_i) disable iff (reset_i)
        store && r.cfg1[`FTM_MON_BIT] |=> r.chan == $past(r.chan) + 3'h1
            && r.state == FTM_ST_INIT)
        else $error("channel scan out of order");

    AST_TIMEOUT: assert property (@(posedge clk_i) disable iff (reset_i)
        (r.state == FTM_ST_INIT || r.state == FTM_ST_MEAS) && cnt_tick
            && r.cnt == 8'hFE && !rise
            |=> r.result[$past(r.chan)] == `FTM_FULL)
        else $error("timeout did not store full count");

    AST_GPIO_NO_MEAS: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_INIT && is_gpio |=> r.state != FTM_ST_MEAS)
        else $error("gpio channel entered measurement");

    AST_FAIL_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
        store |=> r.fail[$past(r.chan)] == ($past(store_val) > $past(r.limit[r.chan])))
        else $error("fail flag does not match limit compare");

    AST_PRESCALE: assert property (@(posedge clk_i) disable iff (reset_i)
        cnt_tick |-> osc_tick && r.psc == div_last(div_code(r.div_lo, r.div_hi, r.chan)))
        else $error("count pulse off prescaler boundary");

    AST_WORST_CASE: assert property (@(posedge clk_i) disable iff (reset_i)
        chan_ticks <= 10'(`FTM_WORST_PULSES))
        else $error("channel exceeded worst-case pulse count");

    AST_INT_OUT: assert property (@(posedge clk_i) disable iff (reset_i)
        (|r.fail) && r.cfg1[`FTM_INTEN_BIT] |-> !int_n_o)
        else $error("interrupt not asserted on fan failure");

    AST_INT_QUIET: assert property (@(posedge clk_i) disable iff (reset_i)
        !(|r.fail) |-> int_n_o)
        else $error("interrupt asserted with no fan failure");

    // an edge on the last tick can park the count at full scale; it must not wrap
    AST_FULL_STOPS: assert property (@(posedge clk_i) disable iff (reset_i)
        (r.state == FTM_ST_INIT || r.state == FTM_ST_MEAS) && cnt_tick && r.cnt == `FTM_FULL
            && !rise |-> store)
        else $error("count ran past full scale");

    AST_COUNT_STEP: assert property (@(posedge clk_i) disable iff (reset_i)
        (r.state == FTM_ST_INIT || r.state == FTM_ST_MEAS) && cnt_tick && !rise && !store
            |=> r.cnt == $past(r.cnt) + 8'h01)
        else $error("counter missed a prescaled pulse");

    AST_GPIO_TIMEOUT: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_INIT && is_gpio && cnt_tick && r.cnt == 8'hFE
            |-> store && store_val == `FTM_FULL)
        else $error("gpio channel did not time out at full count");

    AST_MEAS_STORE: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_MEAS && rise && !is_gpio && r.edges == 2'h3
            |-> store && store_val == r.cnt)
        else $error("fourth tach edge did not end the measurement");

    AST_RESULT_STORE: assert property (@(posedge clk_i) disable iff (reset_i)
        store |=> r.result[$past(r.chan)] == $past(store_val))
        else $error("result register missed the stored count");

    AST_SPIN_LEN: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_SPIN && r.spin != 32'(SPINUP_CYC - 1) |=> r.state != FTM_ST_INIT)
        else $error("measurement began before spin-up ended");

    AST_HOLD_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
        r.state == FTM_ST_IDLE && !r.cfg1[`FTM_MON_BIT] |=> r.state == FTM_ST_IDLE)
        else $error("scan started without the monitor bit");

    AST_LIMIT_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
        reg_req_i.wr && blk_hit(reg_req_i.addr, `FTM_LIMIT_BASE)
            |=> r.limit[$past(reg_req_i.addr[2:0])] == $past(reg_req_i.wdata))
        else $error("limit write did not land");

endmodule
`default_nettype wire

// ### ftm_monitor_tb_top.sv
// self-checking bench for the fan tach period monitor
// assumes ftm_defs.svh on the include path and the fan model compiled before it
`timescale 1ns/1ps
`default_nettype none

module ftm_monitor_tb_top
    import ftm_pkg::*;
();
    // short counts keep a full scan near ten thousand clocks
    localparam int OSC = 4;
    localparam int SPIN = 50;
    localparam int P = 320;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    ftm_reg_req_s req = '0;
    logic [7:0] rdata, fan_fail, tach, v, e;
    logic int_n, astart;
    logic [7:0][15:0] period = '0;
    int fails = 0;
    int n_tests = 0;
    int dv[8] = '{1, 2, 4, 8, 2, 2, 2, 2};
    logic [7:0] row_addr[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h17, 8'h18, 8'h1F,
                                 8'h20, 8'h30, 8'h04};
    logic [7:0] row_exp[11] = '{8'h00, 8'h00, 8'h55, 8'h55, 8'hFF, 8'hFF, 8'h00, 8'h00,
                                8'h00, 8'h00, 8'h00};

    ftm_monitor #(.OSC_CYC(OSC), .SPINUP_CYC(SPIN)) DUT (.clk_i(clk_i), .reset_i(reset_i),
        .reg_req_i(req), .reg_rdata_o(rdata), .tach_i(tach), .fan_fail_o(fan_fail),
        .int_n_o(int_n), .analog_start_o(astart));
    ftm_fan_model fans (.clk_i(clk_i), .period_i(period), .tach_o(tach));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // ************************************************************
    // register port and comparison tasks
    // ************************************************************
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        #1 req.wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        #1 req.rd = 1'b0;
        @(posedge clk_i);
        #1 d = rdata;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_rng(input string name, input logic [7:0] lo, input logic [7:0] hi,
                             input logic [7:0] got);
        n_tests++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
            fails++;
            $display("[ERR] %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // start pulse comes within a few cycles and lasts exactly one
    task automatic start_mon(input logic [7:0] d);
        int n;
        reg_wr(8'h00, d);
        for (n = 0; n < 5 && astart !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        check("analog start", 8'h01, {7'h00, astart});
        if (astart !== 1'b1) results();
        @(posedge clk_i);
        #1 check("analog start end", 8'h00, {7'h00, astart});
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 8; i++) period[i] = P;
        period[5] = 16'h0000;
        repeat (4) @(posedge clk_i);
        #1 reset_i = 1'b0;
        check("int_n after reset", 8'h01, {7'h00, int_n});
        check("fan_fail after reset", 8'h00, fan_fail);
        repeat (300) @(posedge clk_i);
        for (int r = 0; r < 11; r++) begin
            reg_rd(row_addr[r], v);
            check("reset register", row_exp[r], v);
        end
        $display("test reset values done");
        reg_wr(8'h18, 8'hAA);
        reg_wr(8'h01, 8'h80);
        reg_wr(8'h02, 8'hE4);
        reg_wr(8'h14, 8'h40);
        reg_wr(8'h15, 8'hDB);
        reg_wr(8'h03, 8'h15);
        reg_rd(8'h18, v);
        check("read-only result", 8'h00, v);
        reg_rd(8'h01, v);
        check("cfg2", 8'h80, v);
        reg_rd(8'h02, v);
        check("divisor low", 8'hE4, v);
        reg_rd(8'h03, v);
        check("divisor high", 8'h15, v);
        reg_rd(8'h14, v);
        check("limit4", 8'h40, v);
        $display("test configuration done");
        start_mon(8'h03);
        for (int k = 0; k < 8; k++) begin
            int n;
            v = 8'h00;
            for (n = 0; n < 1500 && v == 8'h00; n++) reg_rd(8'h18 + k[7:0], v);
            if (v === 8'h00) begin
                fails++;
                $display("[ERR] result %0d expected nonzero seen 00", k);
                results();
            end
            e = (k == 5 || k == 7) ? 8'hFF : 8'(2 * P / (OSC * dv[k]));
            check_rng("result", e - ((e == 8'hFF) ? 8'h00 : 8'h01),
                      e + ((e == 8'hFF) ? 8'h00 : 8'h01), v);
            if (k < 7) begin
                reg_rd(8'h19 + k[7:0], v);
                check("next result still clear", 8'h00, v);
            end
        end
        $display("test scan done");
        reg_rd(8'h20, v);
        check("fail flags", 8'h30, v);
        check("fan_fail", 8'h30, fan_fail);
        check("int_n active", 8'h00, {7'h00, int_n});
        reg_wr(8'h00, 8'h01);
        @(posedge clk_i);
        #1 check("int_n disabled", 8'h01, {7'h00, int_n});
        $display("test failure flags done");
        reg_wr(8'h00, 8'h00);
        start_mon(8'h01);
        reg_rd(8'h18, v);
        check("result during spin-up", 8'h00, v);
        $display("test restart done");
        reset_i = 1'b1;
        @(posedge clk_i);
        #1 reset_i = 1'b0;
        check("fan_fail after mid reset", 8'h00, fan_fail);
        check("int_n after mid reset", 8'h01, {7'h00, int_n});
        check("analog start after mid reset", 8'h00, {7'h00, astart});
        reg_rd(8'h00, v);
        check("cfg1 after mid reset", 8'h00, v);
        reg_rd(8'h03, v);
        check("divisor high after mid reset", 8'h55, v);
        reg_rd(8'h18, v);
        check("result after mid reset", 8'h00, v);
        $display("test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire

// ### ftm_pkg.sv
// types shared by the fan tach monitor
// assumes ftm_defs.svh is on the include path
`include "ftm_defs.svh"

package ftm_pkg;

    typedef enum logic [1:0] {
        FTM_ST_IDLE,
        FTM_ST_SPIN,
        FTM_ST_INIT,
        FTM_ST_MEAS
    } ftm_state_e;

    // register access port: one-cycle strobes with address and data
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ftm_reg_req_s;

    typedef struct packed {
        ftm_state_e state;
        logic [2:0] chan;
        logic [7:0] cnt;
        logic [2:0] psc;
        logic [1:0] edges;
        logic [15:0] osc;
        logic [31:0] spin;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0][7:0] limit;
        logic [7:0][7:0] result;
        logic [7:0] fail;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] tprev;
        logic [7:0] rdata;
        logic astart;
    } ftm_state_s;

endpackage
